/* File: design/otem_top.sv */
// on-time measurement core with register port and interrupt
//
// Strobed register access and the register addresses were decided locally.
`include "otem_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module otem_top
	import otem_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       high_drive_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	output logic            circuit_enable_o,
	output logic            measure_active_o,
	output logic            irq_o
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisation and edge detect
	logic high_sync;
	logic high_prev;

	otem_sync u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.async_i   (high_drive_i),
		.sync_o    (high_sync)
	);

	function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control register
	logic circuit_en;
	logic measure_en;
	logic next_circuit_en;
	logic next_measure_en;
	logic ctrl_wr;

	assign ctrl_wr = wr_i && is_reg(addr_i, `OTEM_ADDR_CTRL);

	always_comb begin
		next_circuit_en = circuit_en;
		next_measure_en = measure_en;
		if (ctrl_wr) begin
			next_circuit_en = wdata_i[`OTEM_CTRL_CIRCUIT];
			next_measure_en = wdata_i[`OTEM_CTRL_MEASURE];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			circuit_en <= 1'b0;
			measure_en <= 1'b0;
		end else begin
			circuit_en <= next_circuit_en;
			measure_en <= next_measure_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge detect on the synchronised pin
	// resets low, the idle level of the pin, so reset gives no false rise
	logic next_high_prev;

	always_comb begin
		next_high_prev = high_sync;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			high_prev <= 1'b0;
		end else begin
			high_prev <= next_high_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// measurement state machine
	// counts one full high pulse after the start so a pulse already
	// under way is never measured short
	otem_state_t  state;
	otem_state_t  next_state;
	otem_result_t result;
	otem_result_t next_result;
	logic         running;
	logic         rise;
	logic         fall;
	logic         done_evt;
	logic         ovf_evt;

	// cleared result, used on every way back to idle
	function automatic otem_result_t empty_result();
		return '{done: 1'b0, count: `OTEM_COUNT_ZERO};
	endfunction

	assign running = measure_en && circuit_en;
	assign rise    = high_sync && !high_prev;
	assign fall    = !high_sync && high_prev;

	always_comb begin
		next_state  = state;
		next_result = result;
		done_evt    = 1'b0;
		ovf_evt     = 1'b0;
		unique case (state)
			OTEM_IDLE: begin
				next_result = empty_result();
				if (running) begin
					next_state = OTEM_WAIT_RISE;
				end
			end
			OTEM_WAIT_RISE: begin
				if (!running) begin
					next_state  = OTEM_IDLE;
					next_result = empty_result();
				end else if (rise) begin
					next_state        = OTEM_COUNT;
					next_result.count = `OTEM_COUNT_ONE;
				end
			end
			OTEM_COUNT: begin
				if (!running) begin
					next_state  = OTEM_IDLE;
					next_result = empty_result();
				end else if (fall) begin
					next_state       = OTEM_DONE;
					next_result.done = 1'b1;
					done_evt         = 1'b1;
				end else if (result.count == `OTEM_COUNT_MAX) begin
					// saturate rather than wrap: a wrapped count looks valid
					ovf_evt = 1'b1;
				end else begin
					next_result.count = result.count + `OTEM_COUNT_ONE;
				end
			end
			OTEM_DONE: begin
				if (!measure_en) begin
					next_state  = OTEM_IDLE;
					next_result = empty_result();
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state  <= OTEM_IDLE;
			result <= `OTEM_RESET_BYTE;
		end else begin
			state  <= next_state;
			result <= next_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status and mask
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [1:0] next_irq_status;
	logic [1:0] next_irq_mask;
	logic [1:0] irq_set;

	assign irq_set = {ovf_evt, done_evt};

	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (rd_i && is_reg(addr_i, `OTEM_ADDR_IRQ_STATUS)) begin
			next_irq_status = 2'h0;
		end
		// set wins over a clearing read in the same cycle
		next_irq_status = next_irq_status | irq_set;
		if (wr_i && is_reg(addr_i, `OTEM_ADDR_IRQ_MASK)) begin
			next_irq_mask = wdata_i[`OTEM_IRQ_OVERFLOW:`OTEM_IRQ_DONE];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = `OTEM_RESET_BYTE;
		if (rd_i) begin
			unique case (addr_i)
				`OTEM_ADDR_RESULT:     next_rdata = result;
				`OTEM_ADDR_CTRL:       next_rdata = {6'h00, measure_en, circuit_en};
				`OTEM_ADDR_IRQ_STATUS: next_rdata = {6'h00, irq_status};
				`OTEM_ADDR_IRQ_MASK:   next_rdata = {6'h00, irq_mask};
				default:               next_rdata = `OTEM_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata <= `OTEM_RESET_BYTE;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign rdata_o          = rdata;
	assign circuit_enable_o = circuit_en;
	assign measure_active_o = running;
	assign irq_o            = |(irq_status & irq_mask);
endmodule
`default_nettype wire

/* File: design/otem_defines.svh */
// constants for the on-time efficiency measurement block
`ifndef OTEM_DEFINES_SVH
`define OTEM_DEFINES_SVH
`define OTEM_ADDR_RESULT     4'h0
`define OTEM_ADDR_CTRL       4'h1
`define OTEM_ADDR_IRQ_STATUS 4'h2
`define OTEM_ADDR_IRQ_MASK   4'h3
`define OTEM_DONE_BIT        7
`define OTEM_COUNT_MSB       6
`define OTEM_CTRL_CIRCUIT    0
`define OTEM_CTRL_MEASURE    1
`define OTEM_IRQ_DONE        0
`define OTEM_IRQ_OVERFLOW    1
`define OTEM_RESET_BYTE      8'h00
`define OTEM_COUNT_ZERO      7'h00
`define OTEM_COUNT_ONE       7'h01
`define OTEM_COUNT_MAX       7'h7f
`endif

/* File: design/otem_pkg.sv */
// types for the on-time efficiency measurement block
package otem_pkg;
	typedef enum logic [1:0] {
		OTEM_IDLE,
		OTEM_WAIT_RISE,
		OTEM_COUNT,
		OTEM_DONE
	} otem_state_t;

	typedef struct packed {
		logic       done;
		logic [6:0] count;
	} otem_result_t;
endpackage

/* File: design/otem_sync.sv */
// two-flop synchroniser for the gate-drive sense pin
`timescale 1ns/1ns
`default_nettype none
module otem_sync (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic stage1;
	logic stage2;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
		end
	end

	assign sync_o = stage2;
endmodule
`default_nettype wire

/* File: verification/otem_monitor.sv */
// port checker for the on-time measurement block
`timescale 1ns/1ns
`default_nettype none
module otem_monitor (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       measure_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic ctl_wr;
	assign ctl_wr = wr_i && addr_i == 4'h1;
	a_start_measure: assert property (ctl_wr && wdata_i[1:0] == 2'h3 |=> measure_active_o)
		else $error("start ignored");
	a_no_spurious: assert property (!measure_active_o && !ctl_wr |=> !measure_active_o)
		else $error("start without write");
	a_stop_ends: assert property (ctl_wr && !wdata_i[1] |=> !measure_active_o)
		else $error("stop ignored");
	a_done_count: assert property (rd_i && addr_i == 4'h0 ##1 rdata_o[7] |-> rdata_o[6:0] != 7'h00)
		else $error("done with zero count");
	// idle for two cycles, so any result is cleared, except in OTEM_DONE with measure_en still set and circuit_en off
	a_idle_clear: assert property (rd_i && addr_i == 4'h0 && !measure_active_o
		&& !$past(measure_active_o) |=> rdata_o == 8'h00)
		else $error("stale result while idle");
endmodule
bind otem_top otem_monitor mon_u (.*);
`default_nettype wire

/* File: verification/otem_drive_model.sv */
// gate drive pulse source standing in for the power stage
`timescale 1ns/1ns
`default_nettype none
module otem_drive_model (
	input  wire logic clk_i,
	output var logic  high_drive_o
);
	initial high_drive_o = 1'b0;
	// driven low when off, never floating
	task automatic pulse(input int w);
		@(posedge clk_i);
		high_drive_o <= 1'b1;
		repeat (w) @(posedge clk_i);
		high_drive_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: verification/otem_tb_top.sv */
// testbench for the on-time measurement block
`timescale 1ns/1ns
`default_nettype none
module otem_tb_top;
	logic        clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, pin;
	logic [3:0]  addr_i = 4'h0;
	logic [7:0]  wdata_i = 8'h00, rdata_o, e;
	logic        cen, act, irq;
	logic [31:0] seed = 32'h8712_e3af;
	int          fails = 0, tests_run = 0, w;
	always #5 clk_i = ~clk_i;
	otem_drive_model drv_u (.clk_i(clk_i), .high_drive_o(pin));
	otem_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .high_drive_i(pin),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.circuit_enable_o(cen), .measure_active_o(act), .irq_o(irq));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// count saturates, so long pulses read as all ones
	function automatic logic [7:0] exp_res(input int w);
		return {1'b1, (w > 127) ? 7'h7f : w[6:0]};
	endfunction
	// firmware duty in 1/256 steps from adc readings high, low, fraction and period
	localparam int ADC_HI = 800, ADC_LO = 400, ADC_FR = 600, PWM_PER = 127;
	function automatic logic [7:0] duty(input logic [6:0] whole);
		int frac;
		frac = (ADC_FR - ADC_LO) * 256 / (ADC_HI - ADC_LO);
		return 8'((int'(whole) * 256 + frac) / (PWM_PER + 1));
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		tests_run++;
		if (got !== e) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task automatic summarize();
		$display("mismatches %0d of %0d checks", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h00);
		wr(4'h3, 8'h01);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			w = (i == 0) ? 1 : (i == 1) ? 126 : (i == 2) ? 128 : int'(seed[5:0]) + 2;
			e = exp_res(w);
			wr(4'h1, 8'h01);
			#1 chk({6'h00, act, cen}, 8'h01);
			rd(4'h1, 8'h01);
			wr(4'h1, 8'h03);
			drv_u.pulse(w);
			for (int k = 0; k < 300 && irq !== 1'b1; k++) begin
				@(posedge clk_i);
				#1;
			end
			chk({7'h00, irq}, 8'h01);
			rd(4'h0, e);
			chk(duty(rdata_o[6:0]), duty(e[6:0]));
			repeat (50) @(posedge clk_i);
			rd(4'h0, e);
			rd(4'h2, (w > 127) ? 8'h03 : 8'h01);
			chk({7'h00, irq}, 8'h00);
			wr(4'h1, 8'h01);
			rd(4'h0, 8'h00);
		end
		summarize();
	end
	initial begin
		#400000;
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
